// ---- crosspoint_config_latch_control_tb.sv ----
`timescale 1ns/1ns
`include "xcl_map.svh"
module crosspoint_config_latch_control_tb;
  import xcl_pkg::*;
  typedef struct packed
  {
    logic [2:0] cmd;
    logic [4:0] adr;
    logic [6:0] dat;
    logic       rfs;
    logic [4:0] radr;
    logic [6:0] exp;
  } xcl_row_s;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  xcl_bus_s    bus  = '0;
  logic [31:0] rdata;
  xcl_pins_s   pins;
  logic [6:0]  dataIn;
  logic [31:0] v;
  int          n_errors = 0;
  int          cmp_count = 0;
  xcl_row_s    rows [11] = '{
    {3'h1, 5'h03, 7'h45, 1'b0, 5'h03, 7'h00},
    {3'h3, 5'h00, 7'h00, 1'b0, 5'h03, 7'h45},
    {3'h4, 5'h10, 7'h60, 1'b0, 5'h10, 7'h60},
    {3'h1, 5'h11, 7'h47, 1'b0, 5'h00, 7'h00},
    {3'h3, 5'h00, 7'h00, 1'b0, 5'h10, 7'h47},
    {3'h4, 5'h11, 7'h05, 1'b0, 5'h09, 7'h05},
    {3'h4, 5'h02, 7'h60, 1'b0, 5'h02, 7'h60},
    {3'h5, 5'h00, 7'h00, 1'b0, 5'h02, 7'h20},
    {3'h4, 5'h12, 7'h60, 1'b1, 5'h02, 7'h20},
    {3'h1, 5'h00, 7'h21, 1'b1, 5'h00, 7'h05},
    {3'h0, 5'h00, 7'h00, 1'b1, 5'h00, 7'h05}
  };
  always #25 mclk = ~mclk;
  xcl_host i_xcl_host
  (
    .mclk   (mclk),
    .rst    (rst),
    .bus    (bus),
    .rdata  (rdata),
    .pins   (pins),
    .dataIn (dataIn)
  );
  xcl_dev i_xcl_dev
  (
    .pins   (pins),
    .dataIn (dataIn)
  );
  ////////////////////////////////////////
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus <= '{a, d, 1'b0, 1'b0};
  endtask
  task automatic br(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    bus <= '{a, 32'h0, 1'b0, 1'b0};
    #1 d = rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (e !== g)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic run(input logic [2:0] c, input logic [4:0] a,
                     input logic [6:0] d);
    bw(`XCL_REG_ADDR, 32'(a));
    bw(`XCL_REG_DATA, 32'(d));
    bw(`XCL_REG_CMD, 32'(c));
    // Bounded poll so a stuck busy flag cannot hang the run
    for (int i = 0; i < 20; i++)
    begin
      br(`XCL_REG_STATUS, v);
      if (v[0] === 1'b0)
        break;
    end
    chk("busy", 32'h0, 32'(v[0]));
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge mclk);
    chk("idle", 32'h1, 32'(pins.resetN & pins.chipSelN & pins.dataOeN &
        pins.writeN & pins.queryStrobeN & pins.updateN));
    rst <= 1'b0;
    foreach (rows[i])
    begin
      run(rows[i].cmd, rows[i].adr, rows[i].dat);
      chk("refused", 32'(rows[i].rfs), 32'(v[2]));
      chk("done", 32'(!rows[i].rfs), 32'(v[1]));
      run(3'h2, rows[i].radr, 7'h00);
      br(`XCL_REG_RDATA, v);
      chk("row", 32'(rows[i].exp), 32'(v[6:0]));
    end
    run(3'h2, 5'h11, 7'h00);
    chk("bcast read", 32'h1, 32'(v[2]));
    br(8'h14, v);
    chk("unmapped", 32'h0, v);
    bw(`XCL_REG_ADDR, 32'h1);
    bw(`XCL_REG_DATA, 32'h41);
    br(`XCL_REG_DATA, v);
    chk("data reg", 32'h41, v);
    bw(`XCL_REG_CMD, 32'h4);
    bw(`XCL_REG_CMD, 32'h5);
    run(3'h2, 5'h01, 7'h00);
    br(`XCL_REG_RDATA, v);
    chk("busy cmd", 32'h41, 32'(v[6:0]));
    br(`XCL_REG_ADDR, v);
    chk("addr reg", 32'h1, v);
    // Reset cut into a running command: nothing may reach the device
    bw(`XCL_REG_CMD, 32'h4);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("cut pins", 32'h1, 32'(pins.chipSelN & pins.writeN & pins.updateN &
        pins.dataOeN & pins.resetN));
    rst <= 1'b0;
    br(`XCL_REG_STATUS, v);
    chk("cut status", 32'h0, v);
    br(`XCL_REG_ADDR, v);
    chk("cut addr", 32'h0, v);
    run(3'h2, 5'h01, 7'h00);
    br(`XCL_REG_RDATA, v);
    chk("cut row", 32'h41, 32'(v[6:0]));
    report_and_stop;
  end
  initial
  begin
    #500000;
    n_errors++;
    report_and_stop;
  end
endmodule

// ---- xcl_dev.sv ----
`timescale 1ns/1ns
module xcl_dev
(
  input  wire xcl_pkg::xcl_pins_s pins,
  output logic [6:0]              dataIn
);
  import xcl_pkg::*;
  // Power-up contents zero; one procedural driver per variable
  logic [6:0] rank1 [17] = '{default: 7'h00};
  logic [6:0] rank2 [17] = '{default: 7'h00};
  logic [6:0] lastRd     = 7'h00;
  logic [3:0] fn;
  logic       sel;
  ////////////////////////////////////////
  always @(pins)
  begin
    fn = {pins.chipSelN, pins.writeN, pins.queryStrobeN, pins.updateN};
    // With resetN high, chip select high or codes other than 2, 3 and 6 fall through untouched
    for (int i = 0; i < 17; i++)
    begin
      sel = pins.addr == 5'(i) || pins.addr == 5'h11;
      if (pins.resetN === 1'b0)
        rank2[i][6] = 1'b0;
      else if (fn === 4'h3 && sel)
        rank1[i] = pins.dataOut;
      else if (fn === 4'h6)
        rank2[i] = rank1[i];
      else if (fn === 4'h2 && sel)
        rank2[i] = pins.dataOut;
    end
    if (pins.resetN === 1'b1 && fn === 4'h5 && pins.addr < 5'h11)
    begin
      dataIn = rank2[pins.addr];
      lastRd = rank2[pins.addr];
    end
    else if (pins.dataOeN === 1'b0)
      dataIn = pins.dataOut;
    else
      dataIn = ~lastRd; // No pull: released bus must not look valid
  end
endmodule

// ---- xcl_host.sv ----
`timescale 1ns/1ns
`include "xcl_map.svh"
module xcl_host
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire xcl_pkg::xcl_bus_s bus,
  output logic [31:0]            rdata,
  output xcl_pkg::xcl_pins_s     pins,
  input  wire logic [6:0]        dataIn
);
  import xcl_pkg::*;

  typedef struct packed
  {
    xcl_state_e  state;
    logic [2:0]  cmd;
    logic [1:0]  cnt;
    logic [4:0]  addr;
    logic [6:0]  data;
    logic [6:0]  rback;
    logic        refused;
    logic        done;
    xcl_pins_s   pins;
    logic [31:0] rdata;
  } xcl_st_s;

  xcl_st_s st_r;
  xcl_st_s st_nxt;

  localparam logic [1:0] PULSE_CNT = 2'(`XCL_PULSE_CYC);
  localparam logic [1:0] READ_CNT  = 2'(`XCL_READ_CYC);

  function automatic logic legal(input logic [2:0] c,
                                 input logic [4:0] a,
                                 input logic [6:0] d);
    logic ok;
    ok = 1'b1;
    if (c == `XCL_CMD_PREPROG || c == `XCL_CMD_TRANSP)
      ok = (a < `XCL_ADDR_LIMIT) && (d[5:0] < `XCL_INPUT_LIMIT);
    if (c == `XCL_CMD_READBACK)
      ok = (a < `XCL_BCAST);
    if (c == 3'h0 || c > `XCL_CMD_RESET)
      ok = 1'b0;
    return ok;
  endfunction

  // Idle pin pattern: chip deselected, all strobes inactive
  function automatic xcl_pins_s idlePins(input logic [4:0] a,
                                         input logic [6:0] d);
    xcl_pins_s p;
    p = '{resetN: 1'b1, chipSelN: 1'b1, writeN: 1'b1, queryStrobeN: 1'b1,
          updateN: 1'b1, addr: a, dataOut: d, dataOeN: 1'b1};
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    if (bus.rd)
    begin
      case (bus.addr)
        `XCL_REG_ADDR:   st_nxt.rdata = {27'h0, st_r.addr};
        `XCL_REG_DATA:   st_nxt.rdata = {25'h0, st_r.data};
        `XCL_REG_STATUS: st_nxt.rdata = {29'h0, st_r.refused, st_r.done,
                                         st_r.state != XCL_IDLE};
        `XCL_REG_RDATA:  st_nxt.rdata = {25'h0, st_r.rback};
        default:         st_nxt.rdata = 32'h0;
      endcase
    end
    else
      st_nxt.rdata = 32'h0;

    case (st_r.state)
      XCL_IDLE:
      begin
        st_nxt.pins = idlePins(st_r.addr, st_r.data);
        if (bus.wr)
        begin
          case (bus.addr)
            `XCL_REG_ADDR: st_nxt.addr = bus.wdata[4:0];
            `XCL_REG_DATA: st_nxt.data = bus.wdata[6:0];
            `XCL_REG_CMD:
            begin
              st_nxt.done = 1'b0;
              if (legal(bus.wdata[2:0], st_r.addr, st_r.data))
              begin
                st_nxt.cmd     = bus.wdata[2:0];
                st_nxt.refused = 1'b0;
                st_nxt.cnt     = 2'h0;
                st_nxt.state   = XCL_SETUP;
              end
              else
                st_nxt.refused = 1'b1;
            end
            default: ;
          endcase
        end
      end
      XCL_SETUP:
      begin
        // Select, address and data settle a cycle before any strobe
        st_nxt.pins.chipSelN = (st_r.cmd == `XCL_CMD_RESET);
        st_nxt.pins.addr     = st_r.addr;
        st_nxt.pins.dataOut  = st_r.data;
        st_nxt.state         = XCL_PULSE;
        st_nxt.cnt           = 2'h0;
      end
      XCL_PULSE:
      begin
        case (st_r.cmd)
          `XCL_CMD_RESET:    st_nxt.pins.resetN = 1'b0;
          `XCL_CMD_PREPROG:
          begin
            st_nxt.pins.dataOeN = 1'b0;
            st_nxt.pins.writeN  = 1'b0;
          end
          `XCL_CMD_READBACK: st_nxt.pins.queryStrobeN = 1'b0;
          `XCL_CMD_UPDATE:   st_nxt.pins.updateN = 1'b0;
          `XCL_CMD_TRANSP:
          begin
            st_nxt.pins.dataOeN = 1'b0;
            st_nxt.pins.writeN  = 1'b0;
            st_nxt.pins.updateN = 1'b0;
          end
          default: ;
        endcase
        if (st_r.cmd != `XCL_CMD_READBACK && st_r.cmd != `XCL_CMD_UPDATE)
          st_nxt.pins.dataOeN = (st_r.cmd == `XCL_CMD_RESET);
        st_nxt.cnt = st_r.cnt + 2'h1;
        if (st_r.cnt + 2'h1 >= ((st_r.cmd == `XCL_CMD_READBACK) ? READ_CNT
                                                                 : PULSE_CNT))
          st_nxt.state = XCL_HOLD;
      end
      XCL_HOLD:
      begin
        // Device bus stays released while reading; sample committed row
        if (st_r.cmd == `XCL_CMD_READBACK)
          st_nxt.rback = dataIn;
        st_nxt.pins.resetN       = 1'b1;
        st_nxt.pins.writeN       = 1'b1;
        st_nxt.pins.queryStrobeN = 1'b1;
        st_nxt.pins.updateN      = 1'b1;
        st_nxt.state             = XCL_RELAX;
      end
      XCL_RELAX:
      begin
        // Data and select held one more cycle past the strobe edge
        st_nxt.pins  = idlePins(st_r.addr, st_r.data);
        st_nxt.done  = 1'b1;
        st_nxt.state = XCL_IDLE;
      end
      default:
        st_nxt.state = XCL_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r       <= '0;
      st_r.state <= XCL_IDLE;
      st_r.pins  <= idlePins(5'h00, 7'h00);
    end
    else
      st_r <= st_nxt;
  end

  assign rdata = st_r.rdata;
  assign pins  = st_r.pins;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_selected;
    !pins.chipSelN;
  endsequence

  AST_STROBE_NEEDS_SELECT: assert property (@(posedge mclk) disable iff (rst)
    (!pins.writeN || !pins.queryStrobeN || !pins.updateN) |-> s_selected)
    else $error("strobe active while deselected");
  AST_PREPROG_PATTERN: assert property (@(posedge mclk) disable iff (rst)
    (!pins.writeN && pins.updateN) |-> pins.queryStrobeN && pins.resetN)
    else $error("preprogram pattern wrong");
  AST_READ_PATTERN: assert property (@(posedge mclk) disable iff (rst)
    !pins.queryStrobeN |-> pins.writeN && pins.updateN && pins.dataOeN)
    else $error("readback pattern wrong");
  AST_UPDATE_PATTERN: assert property (@(posedge mclk) disable iff (rst)
    (!pins.updateN && pins.writeN) |-> pins.queryStrobeN)
    else $error("update pattern wrong");
  AST_TRANSP_DRIVES: assert property (@(posedge mclk) disable iff (rst)
    (!pins.writeN && !pins.updateN) |-> !pins.dataOeN)
    else $error("transparent write without data drive");
  AST_NO_BCAST_READ: assert property (@(posedge mclk) disable iff (rst)
    !pins.queryStrobeN |-> pins.addr < `XCL_BCAST)
    else $error("readback on broadcast address");
  AST_NO_RESERVED: assert property (@(posedge mclk) disable iff (rst)
    !pins.writeN |-> pins.addr < `XCL_ADDR_LIMIT &&
    pins.dataOut[5:0] < `XCL_INPUT_LIMIT)
    else $error("reserved code written");
  AST_RESET_SHORT: assert property (@(posedge mclk) disable iff (rst)
    $fell(pins.resetN) |=> pins.resetN ##1 pins.resetN)
    else $error("reset pulse length wrong");
  AST_WRITE_SETUP: assert property (@(posedge mclk) disable iff (rst)
    $fell(pins.writeN) |-> !$past(pins.chipSelN))
    else $error("write without select setup");
endmodule

// ---- xcl_map.svh ----
`ifndef XCL_MAP_SVH
`define XCL_MAP_SVH
// Software register byte offsets
`define XCL_REG_CMD      8'h00
`define XCL_REG_ADDR     8'h04
`define XCL_REG_DATA     8'h08
`define XCL_REG_STATUS   8'h0C
`define XCL_REG_RDATA    8'h10
// Command codes written to the command register
`define XCL_CMD_PREPROG  3'h1
`define XCL_CMD_READBACK 3'h2
`define XCL_CMD_UPDATE   3'h3
`define XCL_CMD_TRANSP   3'h4
`define XCL_CMD_RESET    3'h5
// Pin and field widths, on bit, broadcast address, code limits and row count
`define XCL_AW           5
`define XCL_DW           7
`define XCL_ON_BIT       6
`define XCL_BCAST        5'h11
`define XCL_ADDR_LIMIT   5'h12
`define XCL_INPUT_LIMIT  6'h21
`define XCL_ROWS         17
// Timing: pulse widths and setup, in ns and cycles (50 ns clock)
`define XCL_CLK_NS       50
`define XCL_PULSE_NS     15
`define XCL_PULSE_CYC    (((`XCL_PULSE_NS)+(`XCL_CLK_NS)-1)/(`XCL_CLK_NS))
`define XCL_SETUP_CYC    1
`define XCL_READ_NS      30
`define XCL_READ_CYC     (((`XCL_READ_NS)+(`XCL_CLK_NS)-1)/(`XCL_CLK_NS))
`endif

// ---- xcl_pkg.sv ----
package xcl_pkg;
  typedef enum logic [2:0]
  {
    XCL_IDLE   = 3'b000,
    XCL_SETUP  = 3'b001,
    XCL_PULSE  = 3'b010,
    XCL_HOLD   = 3'b011,
    XCL_RELAX  = 3'b100
  } xcl_state_e;

  typedef struct packed
  {
    logic       resetN;
    logic       chipSelN;
    logic       writeN;
    logic       queryStrobeN;
    logic       updateN;
    logic [4:0] addr;
    logic [6:0] dataOut;
    logic       dataOeN;
  } xcl_pins_s;

  typedef struct packed
  {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } xcl_bus_s;
endpackage
